// ===== hsd_pkg.sv
// Constants and types for the hub strap decoder
package hsd_pkg;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned LVL_W     = 3;
  localparam int unsigned SYNC_LEN  = 3;

  // Analog detector level codes for multi-level straps
  localparam logic [2:0] LVL_WEAK_PD   = 3'h0;
  localparam logic [2:0] LVL_WEAK_PU   = 3'h1;
  localparam logic [2:0] LVL_STRONG_PD = 3'h2;
  localparam logic [2:0] LVL_STRONG_PU = 3'h3;
  localparam logic [2:0] LVL_SHORT_PD  = 3'h4;

  // Port masks for 0..4 ports counted from port 1
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_P1   = 4'h1;
  localparam logic [3:0] MASK_P12  = 4'h3;
  localparam logic [3:0] MASK_P123 = 4'h7;
  localparam logic [3:0] MASK_ALL  = 4'hF;

  // Shared pin positions: select/fixed, miso/charge, mosi/data, sck/clock
  localparam int unsigned PIN_SEL  = 3;
  localparam int unsigned PIN_MISO = 2;
  localparam int unsigned PIN_MOSI = 1;
  localparam int unsigned PIN_SCK  = 0;

  // Pin function codes of the shared serial pins
  typedef enum logic [1:0] {
    HSD_PF_RESET = 2'h0,
    HSD_PF_SPI   = 2'h1,
    HSD_PF_SLAVE = 2'h2
  } hsd_pinfunc_e;

  // Boot stage after strap read
  typedef enum logic [1:0] {
    HSD_ST_WAIT  = 2'h0,
    HSD_ST_FLASH = 2'h1,
    HSD_ST_HOST  = 2'h2,
    HSD_ST_OTP   = 2'h3
  } hsd_stage_e;

  localparam logic [15:0] SIG_ADDR = 16'hFFFA;
endpackage

// ===== hsd_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hsd_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pin side
  input  wire logic [W-1:0] pin,
  // Clean side
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule

// ===== hsd_strap_decoder.sv
// Reset-time strap capture and decode for a four-port hub
`timescale 1ns/1ps

// Function
// - Capture all straps once after reset release, hold until next reset.
// - Pull-ups on data-out and clock straps select slave bus pin function.
// - No pull on data-out and clock straps selects flash master function.
// - Route shared pins per selected mode: flash signals or straps and slave bus.
// - Use external flash only when valid signature found at signature address.
// - Positive-line disable strap: 0 enabled, 1 disabled, per port.
// - Negative-line disable strap: 0 enabled, 1 disabled, per port.
// - Port disabled only when both its line-disable straps are high.
// - Disabled high-speed path also disables the matching SuperSpeed path.
// - Decode fixed-port strap level into count of non-removable ports.
// - Decode charge-port strap level into count of charging ports.
// - After capture, go to host-config stage in slave mode, else flash stage, then OTP stage once the signature check is done.
module hsd_strap_decoder
  import hsd_pkg::*;
#(
  parameter int unsigned SETTLE = SYNC_LEN + 1
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Strap levels from pins and analog detectors
  input  wire logic                    dout_pullup,
  input  wire logic                    dclk_pullup,
  input  wire logic [hsd_pkg::NUM_PORTS-1:0] port_pos_line_off,
  input  wire logic [hsd_pkg::NUM_PORTS-1:0] port_neg_line_off,
  input  wire logic [hsd_pkg::LVL_W-1:0]     fixed_port_strap,
  input  wire logic [hsd_pkg::LVL_W-1:0]     charge_port_strap,
  // Flash signature check result from boot firmware
  input  wire logic                    flash_sig_done,
  input  wire logic                    flash_sig_ok,
  // Shared pin inputs in their two roles
  input  wire logic                    flash_miso,
  input  wire logic                    slave_bus_data_in,
  // Flash master side
  input  wire logic                    flash_cs_n_int,
  input  wire logic                    flash_mosi_int,
  input  wire logic                    flash_sck_int,
  output logic                         flash_miso_int,
  // Slave bus side
  input  wire logic                    slave_bus_data_oe_int,
  input  wire logic                    slave_bus_clock_oe_int,
  output logic                         slave_bus_data_int,
  // Shared pin drive
  output logic [3:0]                   pin_out,
  output logic [3:0]                   pin_oe,
  // Decoded configuration
  output logic                         straps_valid,
  output hsd_pkg::hsd_pinfunc_e        pin_func,
  output logic                         flash_enabled,
  output logic [hsd_pkg::NUM_PORTS-1:0] hs_port_off,
  output logic [hsd_pkg::NUM_PORTS-1:0] ss_port_off,
  output logic [hsd_pkg::NUM_PORTS-1:0] fixed_ports,
  output logic [hsd_pkg::NUM_PORTS-1:0] charge_ports,
  output hsd_pkg::hsd_stage_e          boot_stage
);
  localparam int unsigned SW = 2 + 2 * NUM_PORTS + 2 * LVL_W + 2;

  logic [SW-1:0] raw, clean;
  logic [LVL_W-1:0] fix_c, chg_c;
  logic [NUM_PORTS-1:0] pos_c, neg_c;
  logic dout_c, dclk_c, miso_c, sda_c;

  assign raw = {dout_pullup, dclk_pullup, port_pos_line_off, port_neg_line_off,
                fixed_port_strap, charge_port_strap, flash_miso, slave_bus_data_in};

  hsd_sync #(.W(SW)) u_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (raw),
    .level (clean)
  );

  assign {dout_c, dclk_c, pos_c, neg_c, fix_c, chg_c, miso_c, sda_c} = clean;

  function automatic logic [NUM_PORTS-1:0] lvl_mask(input logic [LVL_W-1:0] c);
    unique case (c)
      LVL_WEAK_PU:   lvl_mask = MASK_P1;
      LVL_STRONG_PD: lvl_mask = MASK_P12;
      LVL_STRONG_PU: lvl_mask = MASK_P123;
      LVL_SHORT_PD:  lvl_mask = MASK_ALL;
      default:       lvl_mask = MASK_NONE;
    endcase
  endfunction

  // Capture state
  logic [3:0]           settle_q, settle_d;
  logic                 valid_q, valid_d;
  hsd_pinfunc_e         func_q, func_d;
  logic [NUM_PORTS-1:0] hs_q, hs_d, ss_q, ss_d, fix_q, fix_d, chg_q, chg_d;
  logic                 cap_now, slave_c;

  // Capture fires once, on the settle count after every reset
  assign cap_now = !valid_q && (settle_q == 4'(SETTLE));
  assign slave_c = dout_c && dclk_c;

  always_comb begin
    settle_d = settle_q;
    valid_d  = valid_q;
    func_d   = func_q;
    hs_d     = hs_q;
    fix_d    = fix_q;
    chg_d    = chg_q;
    if (cap_now) begin
      valid_d = 1'b1;
      func_d  = slave_c ? HSD_PF_SLAVE : HSD_PF_SPI;
      hs_d    = pos_c & neg_c;
      fix_d   = lvl_mask(fix_c);
      chg_d   = lvl_mask(chg_c);
    end else if (!valid_q) begin
      settle_d = settle_q + 4'h1;
    end
    ss_d = hs_d;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      settle_q <= 4'h0;
      valid_q  <= 1'b0;
      func_q   <= HSD_PF_RESET;
      hs_q     <= '0;
      ss_q     <= '0;
      fix_q    <= '0;
      chg_q    <= '0;
    end else begin
      settle_q <= settle_d;
      valid_q  <= valid_d;
      func_q   <= func_d;
      hs_q     <= hs_d;
      ss_q     <= ss_d;
      fix_q    <= fix_d;
      chg_q    <= chg_d;
    end
  end

  // Boot stage sequencer
  hsd_stage_e stage_q, stage_d;
  logic       fl_en_q, fl_en_d;

  always_comb begin
    stage_d = stage_q;
    fl_en_d = fl_en_q;
    unique case (stage_q)
      HSD_ST_WAIT: begin
        if (cap_now) begin
          stage_d = slave_c ? HSD_ST_HOST : HSD_ST_FLASH;
        end
      end
      HSD_ST_FLASH: begin
        if (flash_sig_done) begin
          fl_en_d = flash_sig_ok;
          stage_d = HSD_ST_OTP;
        end
      end
      // Terminal stages, left only by reset
      HSD_ST_HOST: begin
        stage_d = HSD_ST_HOST;
      end
      HSD_ST_OTP: begin
        stage_d = HSD_ST_OTP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage_q <= HSD_ST_WAIT;
      fl_en_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      fl_en_q <= fl_en_d;
    end
  end

  // Shared pin mux: index 3 cs/fixed, 2 miso/charge, 1 mosi/data, 0 sck/clock
  logic [3:0] pout_d, poe_d, pout_q, poe_q;
  logic       miso_d, sda_d, miso_q, sda_q;

  always_comb begin
    pout_d = 4'h0;
    poe_d  = 4'h0;
    miso_d = 1'b0;
    sda_d  = 1'b1;
    if (func_q == HSD_PF_SPI && fl_en_q) begin
      pout_d[PIN_SEL]  = flash_cs_n_int;
      pout_d[PIN_MOSI] = flash_mosi_int;
      pout_d[PIN_SCK]  = flash_sck_int;
      poe_d[PIN_SEL]   = 1'b1;
      poe_d[PIN_MOSI]  = 1'b1;
      poe_d[PIN_SCK]   = 1'b1;
      miso_d           = miso_c;
    end else if (func_q == HSD_PF_SLAVE) begin
      poe_d[PIN_MOSI]  = slave_bus_data_oe_int;
      poe_d[PIN_SCK]   = slave_bus_clock_oe_int;
      sda_d            = sda_c;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pout_q <= 4'h0;
      poe_q  <= 4'h0;
      miso_q <= 1'b0;
      sda_q  <= 1'b1;
    end else begin
      pout_q <= pout_d;
      poe_q  <= poe_d;
      miso_q <= miso_d;
      sda_q  <= sda_d;
    end
  end

  assign straps_valid       = valid_q;
  assign pin_func           = func_q;
  assign flash_enabled      = fl_en_q;
  assign hs_port_off        = hs_q;
  assign ss_port_off        = ss_q;
  assign fixed_ports        = fix_q;
  assign charge_ports       = chg_q;
  assign boot_stage         = stage_q;
  assign pin_out            = pout_q;
  assign pin_oe             = poe_q;
  assign flash_miso_int     = miso_q;
  assign slave_bus_data_int = sda_q;
endmodule

// ===== hsd_props.sv
// Port assertions for the strap decoder
`timescale 1ns/1ps
module hsd_props import hsd_pkg::*; (
  input wire logic         clk, rst, dout_pullup, dclk_pullup,
  input wire logic         flash_sig_done, flash_sig_ok, straps_valid, flash_enabled,
  input wire logic [3:0]   port_pos_line_off, port_neg_line_off, hs_port_off, ss_port_off,
  input wire logic [3:0]   fixed_ports, charge_ports,
  input wire logic [2:0]   fixed_port_strap, charge_port_strap,
  input wire hsd_pinfunc_e pin_func,
  input wire hsd_stage_e   boot_stage
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  function automatic logic [3:0] msk(logic [2:0] l);
    return l == 1 ? 4'h1 : l == 2 ? 4'h3 : l == 3 ? 4'h7 : l == 4 ? 4'hF : 4'h0;
  endfunction
  sequence s_cap; $rose(straps_valid); endsequence
  sequence s_rel; $fell(rst); endsequence
  property p_hold; straps_valid && $past(straps_valid)
    |-> $stable({pin_func, hs_port_off, fixed_ports, charge_ports}); endproperty
  a_hold: assert property (p_hold) else $error("settings moved");
  property p_rel; s_rel |-> !straps_valid ##[1:8] straps_valid; endproperty
  a_rel: assert property (p_rel) else $error("no capture");
  property p_func; s_cap
    |-> pin_func == (dout_pullup && dclk_pullup ? HSD_PF_SLAVE : HSD_PF_SPI); endproperty
  a_func: assert property (p_func) else $error("bad pin function");
  property p_off; s_cap |-> hs_port_off == (port_pos_line_off & port_neg_line_off); endproperty
  a_off: assert property (p_off) else $error("bad port off");
  property p_ss; ss_port_off == hs_port_off; endproperty
  a_ss: assert property (p_ss) else $error("ss path differs");
  property p_lvl; s_cap |-> fixed_ports == msk(fixed_port_strap)
    && charge_ports == msk(charge_port_strap); endproperty
  a_lvl: assert property (p_lvl) else $error("bad level decode");
  property p_stage; s_cap
    |-> boot_stage == (pin_func == HSD_PF_SLAVE ? HSD_ST_HOST : HSD_ST_FLASH); endproperty
  a_stage: assert property (p_stage) else $error("bad stage");
  property p_sig; boot_stage == HSD_ST_FLASH && flash_sig_done
    |=> boot_stage == HSD_ST_OTP && flash_enabled == $past(flash_sig_ok); endproperty
  a_sig: assert property (p_sig) else $error("bad flash use");
endmodule
bind hsd_strap_decoder hsd_props u_props (.clk, .rst, .dout_pullup, .dclk_pullup,
  .flash_sig_done, .flash_sig_ok, .straps_valid, .flash_enabled, .port_pos_line_off,
  .port_neg_line_off, .hs_port_off, .ss_port_off, .fixed_ports, .charge_ports,
  .fixed_port_strap, .charge_port_strap, .pin_func, .boot_stage);

// ===== hsd_board.sv
// Board strap resistors and reset source
`timescale 1ns/1ps
module hsd_board (
  input wire logic       clk, rst_req, slave,
  input wire logic [3:0] off_req, half_off,
  input wire logic [2:0] fix_lvl, chg_lvl,
  output logic           rst, dpu, cpu,
  output logic [3:0]     pos, neg,
  output logic [2:0]     fix, chg
);
  initial {rst, dpu, cpu, pos, neg, fix, chg} = 17'h1FFFF;
  always @(posedge clk) begin
    rst <= rst_req;
    dpu <= slave;
    cpu <= slave;
    pos <= off_req | half_off;
    neg <= off_req;
    fix <= fix_lvl;
    chg <= chg_lvl;
  end
endmodule

// ===== hsd_strap_decoder_bench.sv
// Self-checking bench for the strap decoder
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module hsd_strap_decoder_bench;
  import hsd_pkg::*;
  logic         clk = 0, rst_req = 1, slv = 0, sd = 0, sok = 0, es, rst, dpu, cpu, sv, fe, mi;
  logic         sdo;
  logic [6:0]   mis = 0, mis_p;
  logic [1:0]   m1, m2, m3, ml, mo;
  logic [3:0]   off = 0, half = 0, pos, neg, hs, ss, fx, ch, po, poe;
  logic [2:0]   fl = 0, cl = 0, fs, cs;
  logic [11:0]  e;
  hsd_pinfunc_e pf;
  hsd_stage_e   bs;
  int           n_fail = 0, checked = 0, k;
  int unsigned  seed = 35192;
  always #2 clk = ~clk;
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int msk(int l);
    return l == 1 ? 1 : l == 2 ? 3 : l == 3 ? 7 : l == 4 ? 15 : 0;
  endfunction
  // Random shared-pin inputs and a model of the three-stage agreeing input filter
  always @(posedge clk) begin
    mis_p <= mis;
    mis <= 7'(rnd());
    if (rst) begin
      m1 <= '0;
      m2 <= '0;
      m3 <= '0;
      ml <= '0;
      mo <= '0;
    end else begin
      m1 <= mis[1:0];
      m2 <= m1;
      m3 <= m2;
      ml <= (m2 ~^ m3) & m3 | (m2 ^ m3) & ml;
      mo <= ml;
    end
  end
  hsd_board board (.clk, .rst_req, .slave(slv), .off_req(off), .half_off(half),
    .fix_lvl(fl), .chg_lvl(cl), .rst, .dpu, .cpu, .pos, .neg, .fix(fs), .chg(cs));
  hsd_strap_decoder dut (.clk, .rst, .dout_pullup(dpu), .dclk_pullup(cpu),
    .port_pos_line_off(pos), .port_neg_line_off(neg), .fixed_port_strap(fs),
    .charge_port_strap(cs), .flash_sig_done(sd), .flash_sig_ok(sok), .flash_miso(mis[0]),
    .slave_bus_data_in(mis[1]), .flash_cs_n_int(mis[2]), .flash_mosi_int(mis[3]),
    .flash_sck_int(mis[4]), .flash_miso_int(mi), .slave_bus_data_oe_int(mis[5]),
    .slave_bus_clock_oe_int(mis[6]), .slave_bus_data_int(sdo), .pin_out(po), .pin_oe(poe),
    .straps_valid(sv), .pin_func(pf), .flash_enabled(fe), .hs_port_off(hs),
    .ss_port_off(ss), .fixed_ports(fx), .charge_ports(ch), .boot_stage(bs));
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      rst_req <= 1;
      slv <= i[0];
      {off, half} <= 8'(rnd());
      fl <= 3'(i);
      cl <= 3'(i + 3);
      sok <= 1'(rnd());
      repeat (8) @(posedge clk);
      rst_req <= 0;
      for (k = 0; k < 20 && sv !== 1'b1; k++) @(posedge clk);
      @(posedge clk);
      es = slv;
      e = {off, 4'(msk(fl)), 4'(msk(cl))};
      `CHK(sv, 1'b1)
      `CHK(pf, es ? HSD_PF_SLAVE : HSD_PF_SPI)
      `CHK({hs, fx, ch}, e)
      `CHK(ss, e[11:8])
      `CHK(bs, es ? HSD_ST_HOST : HSD_ST_FLASH)
      sd <= 1;
      {off, half, fl, cl, slv} <= 15'(rnd());
      @(posedge clk);
      sd <= 0;
      repeat (3) @(posedge clk);
      `CHK(bs, es ? HSD_ST_HOST : HSD_ST_OTP)
      `CHK(fe, es ? 1'b0 : sok)
      `CHK({hs, fx, ch}, e)
      @(negedge clk);
      if (es) begin
        `CHK(po, 4'h0)
        `CHK(poe, {2'h0, mis_p[5], mis_p[6]})
        `CHK({mi, sdo}, {1'b0, mo[1]})
      end else begin
        `CHK(po, sok ? {mis_p[2], 1'b0, mis_p[3], mis_p[4]} : 4'h0)
        `CHK(poe, sok ? 4'hB : 4'h0)
        `CHK({mi, sdo}, {sok & mo[0], 1'b1})
      end
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule
